//--- verilog/motion_cfg.svh
`ifndef MOTION_CFG_SVH
`define MOTION_CFG_SVH

// Clock rate in kHz; 200 MHz.
`define CLK_KHZ 200000
// Selection pulse limits in nanoseconds.
`define SEL1_MIN_NS 562500
`define SEL1_MAX_NS 883000
`define SEL2_MIN_NS 1125000
`define SEL2_MAX_NS 1570000
`define SEL3_MIN_NS 2250000
`define SEL3_MAX_NS 2950000
// Cycle counts: minimum rounds up, maximum rounds down (ns * kHz / 1e6).
`define NS_TO_CYC_UP(ns, khz) (((ns) * (khz) + 64'd999999) / 64'd1000000)
`define NS_TO_CYC_DN(ns, khz) (((ns) * (khz)) / 64'd1000000)
// Threshold magnitudes in counts.
`define THR_DEFAULT 12'h040
`define THR_ONE 12'h020
`define THR_TWO 12'h060
`define THR_THREE 12'h080
// Plain defaults for durations with no printed figure, in cycles; MOT_DEBOUNCE counts samples over threshold.
`define BOOT_PULSE_CYC 32'd20000
`define WINDOW_CYC 32'd800000
`define MOT_PULSE_CYC 32'd20000
`define HIB_DEB_CYC 32'd200000
`define BOOT_LEN_CYC 32'd40000
`define MOT_DEBOUNCE 4'h2

`endif

//--- verilog/motion_pkg.sv
package motion_pkg;
	typedef enum logic [2:0] {
		ST_BOOT = 3'b000,
		ST_HIBERNATE = 3'b001,
		ST_DETECT = 3'b010,
		ST_MOT_PULSE = 3'b011,
		ST_HIB_WAIT = 3'b100
	} seq_state_t;

	typedef enum logic [1:0] {
		SEL_DEFAULT = 2'b00,
		SEL_ONE = 2'b01,
		SEL_TWO = 2'b10,
		SEL_THREE = 2'b11
	} thr_sel_t;
endpackage

//--- verilog/threshold_select.sv
`include "motion_cfg.svh"

// Measures the host's low pulse inside the selection window and grades its width.
module threshold_select #(
	parameter int unsigned WINDOW_CYC = `WINDOW_CYC,
	parameter int unsigned CLK_KHZ = `CLK_KHZ
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic start,
	input wire logic line_in,
	output motion_pkg::thr_sel_t sel,
	output logic busy
);
	import motion_pkg::*;

	// Limits follow the clock rate, so a slower clock keeps the same pulse widths.
	localparam logic [31:0] S1_MIN = 32'(`NS_TO_CYC_UP(64'(`SEL1_MIN_NS), 64'(CLK_KHZ)));
	localparam logic [31:0] S1_MAX = 32'(`NS_TO_CYC_DN(64'(`SEL1_MAX_NS), 64'(CLK_KHZ)));
	localparam logic [31:0] S2_MIN = 32'(`NS_TO_CYC_UP(64'(`SEL2_MIN_NS), 64'(CLK_KHZ)));
	localparam logic [31:0] S2_MAX = 32'(`NS_TO_CYC_DN(64'(`SEL2_MAX_NS), 64'(CLK_KHZ)));
	localparam logic [31:0] S3_MIN = 32'(`NS_TO_CYC_UP(64'(`SEL3_MIN_NS), 64'(CLK_KHZ)));
	localparam logic [31:0] S3_MAX = 32'(`NS_TO_CYC_DN(64'(`SEL3_MAX_NS), 64'(CLK_KHZ)));

	// Maps a measured width to a selection; anything off-table keeps the default.
	function automatic thr_sel_t grade(input logic [31:0] w);
		if (w >= S1_MIN && w <= S1_MAX) begin
			grade = SEL_ONE;
		end else if (w >= S2_MIN && w <= S2_MAX) begin
			grade = SEL_TWO;
		end else if (w >= S3_MIN && w <= S3_MAX) begin
			grade = SEL_THREE;
		end else begin
			grade = SEL_DEFAULT;
		end
	endfunction

	logic [31:0] win_cnt, next_win_cnt;
	logic [31:0] low_cnt, next_low_cnt;
	logic in_low, next_in_low;
	logic seen, next_seen;
	logic armed, next_armed;
	logic active, next_active;
	thr_sel_t next_sel;

	// One pulse is judged per window; a pulse still low at window end is discarded.
	always_comb begin
		next_win_cnt = win_cnt;
		next_low_cnt = low_cnt;
		next_in_low = in_low;
		next_seen = seen;
		next_armed = armed;
		next_active = active;
		next_sel = sel;
		if (start) begin
			next_active = 1'b1;
			next_win_cnt = '0;
			next_low_cnt = '0;
			next_in_low = 1'b0;
			next_seen = 1'b0;
			next_armed = 1'b0;
			next_sel = SEL_DEFAULT;
		end else if (active) begin
			next_win_cnt = win_cnt + 32'h1;
			if (win_cnt + 32'h1 >= WINDOW_CYC) begin
				next_active = 1'b0;
			end
			if (!seen) begin
				// A pulse that fell before the window opened is never graded.
				if (line_in) begin
					next_armed = 1'b1;
				end
				if (!line_in && armed) begin
					next_in_low = 1'b1;
					next_low_cnt = low_cnt + 32'h1;
				end else if (line_in && in_low) begin
					next_in_low = 1'b0;
					next_seen = 1'b1;
					next_sel = grade(low_cnt);
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			win_cnt <= '0;
			low_cnt <= '0;
			in_low <= 1'b0;
			seen <= 1'b0;
			armed <= 1'b0;
			active <= 1'b0;
			sel <= SEL_DEFAULT;
		end else begin
			win_cnt <= next_win_cnt;
			low_cnt <= next_low_cnt;
			in_low <= next_in_low;
			seen <= next_seen;
			armed <= next_armed;
			active <= next_active;
			sel <= next_sel;
		end
	end

	assign busy = active;
endmodule // threshold_select

//--- verilog/motion_seq.sv
`include "motion_cfg.svh"

module motion_seq #(
	parameter int unsigned BOOT_LEN_CYC = `BOOT_LEN_CYC,
	parameter int unsigned BOOT_PULSE_CYC = `BOOT_PULSE_CYC,
	parameter int unsigned WINDOW_CYC = `WINDOW_CYC,
	parameter int unsigned MOT_PULSE_CYC = `MOT_PULSE_CYC,
	parameter int unsigned HIB_DEB_CYC = `HIB_DEB_CYC,
	parameter int unsigned CLK_KHZ = `CLK_KHZ,
	parameter int unsigned DATA_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic boot_strap_select,
	input wire logic motion_line_in,
	output logic motion_line_out,
	output logic motion_line_oe_n,
	output logic boot_out_out,
	output logic boot_out_oe_n,
	input wire logic sample_valid,
	input wire logic signed [DATA_W-1:0] sample,
	output logic sensor_active,
	output logic hibernating,
	output motion_pkg::thr_sel_t thr_sel,
	output logic motion_event
);
	import motion_pkg::*;

	seq_state_t state, next_state;
	logic [31:0] cnt, next_cnt;
	logic [3:0] deb, next_deb;
	logic strap_mode, next_strap_mode;
	logic strap_taken, next_strap_taken;
	logic next_motion_oe_n, next_boot_oe_n, next_active, next_hib, next_event;
	logic sel_start;
	logic sel_busy;
	thr_sel_t sel_val;

	threshold_select #(
		.WINDOW_CYC(WINDOW_CYC),
		.CLK_KHZ(CLK_KHZ)
	) u_sel (
		.ref_clk(ref_clk),
		.rst(rst),
		.start(sel_start),
		.line_in(motion_line_in),
		.sel(sel_val),
		.busy(sel_busy)
	);

	// Threshold magnitude for the chosen setting.
	function automatic logic signed [DATA_W-1:0] thr_mag(input thr_sel_t s);
		case (s)
			SEL_ONE: thr_mag = DATA_W'(`THR_ONE);
			SEL_TWO: thr_mag = DATA_W'(`THR_TWO);
			SEL_THREE: thr_mag = DATA_W'(`THR_THREE);
			default: thr_mag = DATA_W'(`THR_DEFAULT);
		endcase
	endfunction

	logic signed [DATA_W-1:0] mag;
	logic over;

	// Symmetric compare; a sample beyond either bound counts toward debounce.
	always_comb begin
		mag = thr_mag(thr_sel);
		over = (sample > mag) || (sample < -mag);
	end

	// Window start coincides with the boot pulse's release edge.
	assign sel_start = (state == ST_BOOT) && (cnt == BOOT_PULSE_CYC) && strap_mode;

	// Main sequencer. The strap is caught once after reset release, since the
	// asynchronous reset may only load constants.
	always_comb begin
		next_state = state;
		next_cnt = cnt + 32'h1;
		next_deb = deb;
		next_strap_mode = strap_mode;
		next_strap_taken = 1'b1;
		next_motion_oe_n = 1'b1;
		next_boot_oe_n = 1'b1;
		next_active = sensor_active;
		next_hib = 1'b0;
		next_event = 1'b0;
		if (!strap_taken) begin
			next_strap_mode = boot_strap_select;
			next_cnt = '0;
		end
		case (state)
			ST_BOOT: begin
				// Input stays live throughout boot; boot output pulled low first.
				next_boot_oe_n = !(strap_mode && strap_taken && cnt < BOOT_PULSE_CYC);
				// Stale debounce hits must not carry into a later detection phase.
				next_deb = '0;
				if (!strap_mode) begin
					next_cnt = '0; // Register-controlled boot lies outside this block.
				end else if (cnt + 32'h1 >= BOOT_LEN_CYC && !sel_busy) begin
					next_cnt = '0;
					if (motion_line_in) begin
						next_state = ST_DETECT;
						next_active = 1'b1;
					end else begin
						next_state = ST_HIBERNATE;
						next_hib = 1'b1;
					end
				end
			end
			ST_HIBERNATE: begin
				next_cnt = '0;
				next_hib = 1'b1;
				next_active = 1'b0;
				if (motion_line_in) begin
					next_state = ST_BOOT;
					next_hib = 1'b0;
				end
			end
			ST_DETECT: begin
				next_cnt = '0;
				// Serial accesses elsewhere are not blocked by this state.
				if (!motion_line_in) begin
					next_state = ST_HIB_WAIT;
					next_deb = '0;
				end else if (sample_valid) begin
					if (over) begin
						next_deb = deb + 4'h1;
						if (deb + 4'h1 >= `MOT_DEBOUNCE) begin
							next_deb = '0;
							next_state = ST_MOT_PULSE;
							next_motion_oe_n = 1'b0;
							next_event = 1'b1;
						end
					end else begin
						next_deb = '0;
					end
				end
			end
			ST_MOT_PULSE: begin
				// Our own pulse must not be read as a hibernate request.
				next_motion_oe_n = 1'b0;
				if (cnt + 32'h1 >= MOT_PULSE_CYC) begin
					next_motion_oe_n = 1'b1;
					next_cnt = '0;
					next_state = ST_DETECT;
				end
			end
			ST_HIB_WAIT: begin
				if (motion_line_in) begin
					next_state = ST_DETECT;
					next_cnt = '0;
				end else if (cnt + 32'h1 >= HIB_DEB_CYC) begin
					next_state = ST_HIBERNATE;
					next_active = 1'b0;
					next_hib = 1'b1;
				end
			end
			default: begin
				next_state = ST_BOOT;
				next_cnt = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ST_BOOT;
			cnt <= '0;
			deb <= '0;
			strap_mode <= 1'b0;
			strap_taken <= 1'b0;
			motion_line_oe_n <= 1'b1;
			boot_out_oe_n <= 1'b1;
			sensor_active <= 1'b0;
			hibernating <= 1'b0;
			motion_event <= 1'b0;
			thr_sel <= SEL_DEFAULT;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			deb <= next_deb;
			strap_mode <= next_strap_mode;
			strap_taken <= next_strap_taken;
			motion_line_oe_n <= next_motion_oe_n;
			boot_out_oe_n <= next_boot_oe_n;
			sensor_active <= next_active;
			hibernating <= next_hib;
			motion_event <= next_event;
			thr_sel <= sel_val;
		end
	end

	// Open-drain pins only ever pull low.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			motion_line_out <= 1'b0;
			boot_out_out <= 1'b0;
		end else begin
			motion_line_out <= 1'b0;
			boot_out_out <= 1'b0;
		end
	end
endmodule // motion_seq

//--- verif/host_model.sv
module host_model (
	input logic pullup_en,
	input logic host_low,
	input logic motion_line_oe_n,
	input logic boot_out_oe_n,
	output logic motion_line,
	output logic boot_line
);
	timeunit 1ns;
	timeprecision 1ps;
	// One pull-up serves both nets; with it off the host pin holds them low.
	assign boot_line = pullup_en & boot_out_oe_n;
	// The host pulls low to select or to sleep, the device to signal motion; otherwise the pull-up raises it.
	assign motion_line = pullup_en & motion_line_oe_n & !host_low;
endmodule // host_model

//--- verif/motion_seq_monitor.sv
module motion_seq_monitor #(
	parameter int BOOT_PULSE_CYC = 100,
	parameter int MOT_PULSE_CYC = 50,
	parameter int HIB_DEB_CYC = 150,
	parameter int DATA_W = 12
) (
	input logic ref_clk,
	input logic rst,
	input logic boot_strap_select,
	input logic motion_line_in,
	input logic motion_line_out,
	input logic motion_line_oe_n,
	input logic boot_out_out,
	input logic boot_out_oe_n,
	input logic sample_valid,
	input logic signed [DATA_W-1:0] sample,
	input logic sensor_active,
	input logic hibernating,
	input motion_pkg::thr_sel_t thr_sel,
	input logic motion_event
);
	import motion_pkg::*;
	localparam int BPM = BOOT_PULSE_CYC - 1;
	localparam int MPM = MOT_PULSE_CYC - 1;
	localparam int HDM = HIB_DEB_CYC - 1;
	int unsigned low_cnt;
	int unsigned next_low_cnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Run length of a low line; a motion pulse never overlaps a sleep request.
	always_comb begin
		next_low_cnt = motion_line_in ? 0 : low_cnt + 1;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end
	a_pins_low: assert property (!motion_line_out && !boot_out_out)
		else $error("open-drain data not low");
	a_boot_pulse: assert property ($fell(boot_out_oe_n) |-> ##BPM !boot_out_oe_n ##1 boot_out_oe_n)
		else $error("boot pulse length wrong");
	a_hib_quiet: assert property (hibernating |-> motion_line_oe_n && boot_out_oe_n && !sensor_active)
		else $error("outputs busy while asleep");
	a_wake_boot: assert property (hibernating && motion_line_in |-> ##[1:12] !boot_out_oe_n)
		else $error("no boot after wake");
	a_mot_pulse: assert property ($fell(motion_line_oe_n) |-> ##MPM !motion_line_oe_n ##1 motion_line_oe_n)
		else $error("motion pulse length wrong");
	a_event_start: assert property ($fell(motion_line_oe_n) |-> motion_event ##1 !motion_event)
		else $error("event flag not one cycle");
	a_event_detect: assert property ($fell(motion_line_oe_n) |-> sensor_active && !hibernating)
		else $error("motion outside detection");
	a_hib_debounce: assert property ($rose(hibernating) && $past(sensor_active) |-> low_cnt >= HDM)
		else $error("sleep before debounce");
	a_active_high: assert property ($rose(sensor_active) |-> $past(motion_line_in) && boot_out_oe_n)
		else $error("active set with line low");
endmodule // motion_seq_monitor

bind motion_seq motion_seq_monitor #(.BOOT_PULSE_CYC(BOOT_PULSE_CYC),
	.MOT_PULSE_CYC(MOT_PULSE_CYC), .HIB_DEB_CYC(HIB_DEB_CYC), .DATA_W(DATA_W)) mon (
	.ref_clk(ref_clk),
	.rst(rst),
	.boot_strap_select(boot_strap_select),
	.motion_line_in(motion_line_in),
	.motion_line_out(motion_line_out),
	.motion_line_oe_n(motion_line_oe_n),
	.boot_out_out(boot_out_out),
	.boot_out_oe_n(boot_out_oe_n),
	.sample_valid(sample_valid),
	.sample(sample),
	.sensor_active(sensor_active),
	.hibernating(hibernating),
	.thr_sel(thr_sel),
	.motion_event(motion_event)
);

//--- verif/motion_seq_tb_top.sv
module motion_seq_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import motion_pkg::*;
	localparam int BP = 100;
	localparam int MP = 50;
	localparam int HD = 150;
	logic ref_clk = 0, rst = 1, boot_strap_select = 1, sample_valid = 0;
	logic pullup_en = 0, host_low = 0, boot_line, motion_line_in;
	logic signed [11:0] sample = 12'sh000;
	logic motion_line_out, motion_line_oe_n, boot_out_out, boot_out_oe_n;
	logic sensor_active, hibernating, motion_event;
	thr_sel_t thr_sel;
	int err_count = 0, cmp_count = 0;
	// The clock rate is declared as 200 kHz so that every selection width fits a short run.
	motion_seq #(.BOOT_LEN_CYC(900), .BOOT_PULSE_CYC(BP), .WINDOW_CYC(700),
		.MOT_PULSE_CYC(MP), .HIB_DEB_CYC(HD), .CLK_KHZ(200), .DATA_W(12)) uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.boot_strap_select(boot_strap_select),
		.motion_line_in(motion_line_in),
		.motion_line_out(motion_line_out),
		.motion_line_oe_n(motion_line_oe_n),
		.boot_out_out(boot_out_out),
		.boot_out_oe_n(boot_out_oe_n),
		.sample_valid(sample_valid),
		.sample(sample),
		.sensor_active(sensor_active),
		.hibernating(hibernating),
		.thr_sel(thr_sel),
		.motion_event(motion_event)
	);
	host_model host (
		.pullup_en(pullup_en),
		.host_low(host_low),
		.motion_line_oe_n(motion_line_oe_n),
		.boot_out_oe_n(boot_out_oe_n),
		.motion_line(motion_line_in),
		.boot_line(boot_line)
	);
	// Free-running 200 MHz clock.
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input string nm, input int exp, input logic [11:0] got);
		cmp_count++;
		if (got !== exp[11:0]) begin
			err_count++;
			$display("mismatch %s expected %0d seen %0d", nm, exp, got);
		end
	endtask
	// Bounded wait, so a stuck output is reported instead of hanging the run.
	task automatic wt(input string nm, ref logic s, input logic v, input int n);
		int i;
		i = 0;
		while (s !== v && i < n) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		chk(nm, v, s);
	endtask
	task automatic len(input string nm, ref logic s, input int exp);
		int n;
		n = 0;
		while (s === 1'b0 && n < 999) begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		chk(nm, exp, n[11:0]);
	endtask
	task automatic smp(input logic signed [11:0] v);
		@(posedge ref_clk);
		sample <= v;
		sample_valid <= 1'b1;
		@(posedge ref_clk);
		sample_valid <= 1'b0;
		#1;
	endtask
	task automatic t_cold;
		wt("boot drive", boot_out_oe_n, 0, 10);
		chk("hidden pulse", 0, boot_line);
		len("boot pulse", boot_out_oe_n, BP);
		wt("sleep", hibernating, 1, 1000);
		chk("idle", 0, sensor_active);
		$display("test cold done");
	endtask
	// A 20-cycle low pulse fits no entry, so the default must survive.
	task automatic t_wake;
		cyc(5);
		pullup_en <= 1'b1;
		wt("wake", hibernating, 0, 20);
		wt("boot again", boot_line, 0, 20);
		len("seen pulse", boot_line, BP);
		cyc(10);
		host_low <= 1'b1;
		cyc(20);
		host_low <= 1'b0;
		wt("active", sensor_active, 1, 1000);
		chk("threshold", SEL_DEFAULT, thr_sel);
		$display("test wake done");
	endtask
	// Values clear of the 64 edge; a lone hit must not fire.
	task automatic t_motion;
		smp(12'sd60);
		smp(12'sd60);
		smp(12'sd70);
		smp(12'sd0);
		smp(-12'sd70);
		cyc(3);
		#1;
		chk("no event", 1, motion_line_oe_n);
		smp(-12'sd70);
		wt("event", motion_line_oe_n, 0, 5);
		chk("event flag", 1, motion_event);
		len("motion pulse", motion_line_oe_n, MP);
		$display("test motion done");
	endtask
	task automatic t_sleep;
		cyc(1);
		host_low <= 1'b1;
		cyc(HD - 10);
		#1;
		chk("early sleep", 0, hibernating);
		wt("sleep", hibernating, 1, 30);
		chk("stopped", 0, sensor_active);
		cyc(1);
		host_low <= 1'b0;
		wt("active", sensor_active, 1, 1000);
		chk("threshold", SEL_DEFAULT, thr_sel);
		$display("test sleep done");
	endtask
	// Sends the device to sleep, wakes it and sends a selection pulse of w cycles.
	task automatic reboot_with_pulse(input int w);
		cyc(1);
		host_low <= 1'b1;
		wt("sleep", hibernating, 1, 300);
		cyc(1);
		host_low <= 1'b0;
		wt("boot again", boot_line, 0, 20);
		len("seen pulse", boot_line, BP);
		cyc(10);
		host_low <= 1'b1;
		cyc(w);
		host_low <= 1'b0;
		wt("active", sensor_active, 1, 1000);
	endtask
	// Nominal setting-one width; 40 counts lies between the new and the default bound.
	task automatic t_sel_one;
		reboot_with_pulse(125);
		chk("setting one", SEL_ONE, thr_sel);
		smp(12'sd40);
		smp(12'sd40);
		wt("beyond one", motion_line_oe_n, 0, 5);
		len("motion pulse", motion_line_oe_n, MP);
		$display("test setting one done");
	endtask
	// Nominal setting-two width; 90 counts must now stay quiet.
	task automatic t_sel_two;
		reboot_with_pulse(250);
		chk("setting two", SEL_TWO, thr_sel);
		smp(12'sd90);
		smp(12'sd90);
		chk("inside two", 1, motion_line_oe_n);
		smp(12'sd100);
		smp(12'sd100);
		wt("beyond two", motion_line_oe_n, 0, 5);
		len("motion pulse", motion_line_oe_n, MP);
		$display("test setting two done");
	endtask
	// Nominal setting-three width; both signs are checked against the widest bound.
	task automatic t_sel_three;
		reboot_with_pulse(500);
		chk("setting three", SEL_THREE, thr_sel);
		smp(12'sd120);
		smp(-12'sd120);
		chk("inside three", 1, motion_line_oe_n);
		smp(-12'sd130);
		smp(-12'sd130);
		wt("beyond three", motion_line_oe_n, 0, 5);
		len("motion pulse", motion_line_oe_n, MP);
		$display("test setting three done");
	endtask
	initial begin
		cyc(20);
		rst <= 1'b0;
		t_cold;
		t_wake;
		t_motion;
		t_sleep;
		t_sel_one;
		t_sel_two;
		t_sel_three;
		end_of_test;
	end
	// The sequence needs a few thousand cycles; this is ample margin.
	initial begin
		cyc(20000);
		err_count++;
		$display("mismatch watchdog expected done seen timeout");
		end_of_test;
	end
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
endmodule // motion_seq_tb_top
